// [rtl/light_measurement_ctrl.sv]
// light measurement controller: converters, sequencer, thresholds, interrupt, register file
// assumes a classic wishbone master on clk_i and pins that are asynchronous to clk_i
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "light_measurement_regs.svh"

module light_measurement_ctrl #(
    parameter int STEP_CYCLES = `LM_STEP_CYCLES,
    parameter logic [6:0] TARGET_ADDR = 7'h2A
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic broadband_pulse_i,
    input wire logic infrared_pulse_i,
    input wire logic int_pin_i,
    output logic int_pin_o,
    output logic int_pin_oe_n_o,
    output logic irq_o
);

    localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

    light_measurement_pkg::ctrl_regs_type q;
    light_measurement_pkg::ctrl_regs_type next_q;
    logic [7:0] i2c_ptr, i2c_wr_addr, i2c_wr_data, i2c_rd_data;
    logic i2c_wr_stb, wb_hit, tick, run, start_int, ev_thr, ev_done, out_range;
    logic [3:0] cnt_next;
    logic [16:0] gain_step;
    logic [31:0] i2c_word;

    // ----------------------------------------
    // register access helpers
    // ----------------------------------------
    function automatic logic [31:0] read_reg(input light_measurement_pkg::ctrl_regs_type s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a & 8'hFC)
            `LM_ENABLE_OFS: r[7:0] = s.enable;
            `LM_ITIME_OFS: r[7:0] = s.itime;
            `LM_WTIME_OFS: r[7:0] = s.wtime;
            `LM_CONFIG_OFS: r[1] = s.long_wait;
            `LM_THR_LO_OFS: r[15:0] = s.thr_lo;
            `LM_THR_HI_OFS: r[15:0] = s.thr_hi;
            `LM_PERSIST_OFS: r[3:0] = s.persist;
            `LM_GAIN_OFS: r[1:0] = s.gain;
            `LM_STATUS_OFS: r[6:0] = {s.pin_s2, 1'b0, s.state, s.out_cnt == 4'h0, s.out_flag, s.valid};
            `LM_DATA_BB_OFS: r[15:0] = s.data_bb;
            `LM_DATA_IR_OFS: r[15:0] = s.data_ir;
            `LM_IRQ_STAT_OFS: r[1:0] = s.irq_stat;
            `LM_IRQ_EN_OFS: r[1:0] = s.irq_en;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    function automatic light_measurement_pkg::ctrl_regs_type write_reg(
        input light_measurement_pkg::ctrl_regs_type s, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] m);
        light_measurement_pkg::ctrl_regs_type r;
        logic [31:0] bm;
        logic [31:0] w;
        r = s;
        bm = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
        w = (read_reg(s, a) & ~bm) | (d & bm);
        case (a & 8'hFC)
            `LM_ENABLE_OFS: r.enable = w[7:0];
            `LM_ITIME_OFS: r.itime = w[7:0];
            `LM_WTIME_OFS: r.wtime = w[7:0];
            `LM_CONFIG_OFS: r.long_wait = w[1];
            `LM_THR_LO_OFS: r.thr_lo = w[15:0];
            `LM_THR_HI_OFS: r.thr_hi = w[15:0];
            `LM_PERSIST_OFS: r.persist = w[3:0];
            `LM_GAIN_OFS: r.gain = w[1:0];
            `LM_IRQ_CLEAR_OFS: r.irq_stat = s.irq_stat & ~(d[1:0] & bm[1:0]);
            `LM_IRQ_EN_OFS: r.irq_en = w[1:0];
            default: r = s;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [16:0] g);
        logic [16:0] sum;
        sum = {1'b0, a} + g;
        return sum[16] ? 16'hFFFF : sum[15:0];
    endfunction

    // ----------------------------------------
    // serial target
    // ----------------------------------------
    // the serial side only sees bytes; a word's lanes are picked by the low address bits
    assign i2c_word = read_reg(q, i2c_ptr);
    assign i2c_rd_data = i2c_word[8 * i2c_ptr[1:0] +: 8];

    i2c_register_target #(
        .TARGET_ADDR(TARGET_ADDR)
    ) u_target (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o),
        .rd_data_i(i2c_rd_data),
        .ptr_o(i2c_ptr),
        .wr_stb_o(i2c_wr_stb),
        .wr_addr_o(i2c_wr_addr),
        .wr_data_o(i2c_wr_data)
    );

    // ----------------------------------------
    // sequencer helpers
    // ----------------------------------------
    assign tick = (q.presc == STEP_LAST);
    assign run = q.enable[`LM_EN_POWER] & q.enable[`LM_EN_MEASURE];
    assign out_range = (q.acc_bb > q.thr_hi) || (q.acc_bb < q.thr_lo);
    assign cnt_next = !out_range ? 4'h0 : (q.out_cnt == 4'hF) ? 4'hF : q.out_cnt + 4'h1;

    always_comb
    begin
        unique case (q.gain)
            2'h0: gain_step = `LM_GAIN_X1;
            2'h1: gain_step = `LM_GAIN_X8;
            2'h2: gain_step = `LM_GAIN_X16;
            2'h3: gain_step = `LM_GAIN_X120;
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_q = q;
        start_int = 1'b0;
        ev_thr = 1'b0;
        ev_done = 1'b0;
        next_q.bb_s1 = broadband_pulse_i;
        next_q.bb_s2 = q.bb_s1;
        next_q.bb_q = q.bb_s2;
        next_q.ir_s1 = infrared_pulse_i;
        next_q.ir_s2 = q.ir_s1;
        next_q.ir_q = q.ir_s2;
        next_q.pin_s1 = int_pin_i;
        next_q.pin_s2 = q.pin_s1;

        // serial write first, bus write second, so the bus write wins any byte that both hit in one cycle
        if (i2c_wr_stb)
            next_q = write_reg(next_q, i2c_wr_addr, {4{i2c_wr_data}}, 4'h1 << i2c_wr_addr[1:0]);
        wb_hit = wb_cyc_i & wb_stb_i & ~q.wb_ack;
        if (wb_hit && wb_we_i)
            next_q = write_reg(next_q, wb_adr_i, wb_dat_i, wb_sel_i);
        next_q.wb_ack = wb_hit;
        next_q.wb_dat = wb_hit && !wb_we_i ? read_reg(q, wb_adr_i) : 32'h0000_0000;

        next_q.presc = tick ? 16'h0000 : q.presc + 16'h0001;
        if (q.state == light_measurement_pkg::seq_integrate)
        begin
            if (q.bb_s2 && !q.bb_q)
                next_q.acc_bb = sat_add(q.acc_bb, gain_step);
            if (q.ir_s2 && !q.ir_q)
                next_q.acc_ir = sat_add(q.acc_ir, gain_step);
        end

        unique case (q.state)
            light_measurement_pkg::seq_sleep:
            begin
                next_q.presc = 16'h0000;
                if (run && !(q.enable[`LM_EN_SLEEP_IRQ] && q.irq_stat[`LM_IRQ_THR]))
                    start_int = 1'b1;
            end
            light_measurement_pkg::seq_integrate:
            begin
                if (!run)
                    next_q.state = light_measurement_pkg::seq_sleep;
                else if (tick && q.steps == 12'h001)
                begin
                    // in-progress sums stay hidden until this copy
                    next_q.data_bb = q.acc_bb;
                    next_q.data_ir = q.acc_ir;
                    next_q.valid = 1'b1;
                    next_q.out_flag = out_range;
                    next_q.out_cnt = cnt_next;
                    ev_done = 1'b1;
                    ev_thr = (q.persist == 4'h0) || (out_range && cnt_next >= q.persist);
                    if (ev_thr && q.enable[`LM_EN_SLEEP_IRQ])
                        next_q.state = light_measurement_pkg::seq_sleep;
                    else if (q.enable[`LM_EN_WAIT])
                    begin
                        next_q.state = light_measurement_pkg::seq_wait;
                        next_q.steps = 12'(({4'h0, `LM_STEP_FULL - {4'h0, q.wtime}}) *
                            (q.long_wait ? `LM_LONG_WAIT_MUL : 4'h1));
                    end
                    else
                        start_int = 1'b1;
                end
                else if (tick)
                    next_q.steps = q.steps - 12'h001;
            end
            light_measurement_pkg::seq_wait:
            begin
                if (!run)
                    next_q.state = light_measurement_pkg::seq_sleep;
                else if (tick && q.steps == 12'h001)
                    start_int = 1'b1;
                else if (tick)
                    next_q.steps = q.steps - 12'h001;
            end
        endcase

        if (start_int)
        begin
            next_q.state = light_measurement_pkg::seq_integrate;
            next_q.steps = `LM_STEP_FULL - {4'h0, q.itime};
            next_q.presc = 16'h0000;
            next_q.acc_bb = 16'h0000;
            next_q.acc_ir = 16'h0000;
        end

        // ----------------------------------------
        // interrupt
        // ----------------------------------------
        // set after the clear so an event in the clearing cycle survives
        next_q.irq_stat = next_q.irq_stat | {ev_done, ev_thr};
        next_q.irq = |(next_q.irq_stat & next_q.irq_en);
        next_q.int_oe_n = ~(next_q.enable[`LM_EN_IRQ] & next_q.irq_stat[`LM_IRQ_THR]);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.enable <= `LM_ENABLE_RST;
            q.itime <= `LM_ITIME_RST;
            q.wtime <= `LM_WTIME_RST;
            q.thr_lo <= `LM_THR_LO_RST;
            q.thr_hi <= `LM_THR_HI_RST;
            q.persist <= `LM_PERSIST_RST;
            q.gain <= `LM_GAIN_RST;
            q.state <= light_measurement_pkg::seq_sleep;
            q.int_oe_n <= 1'b1;
            q.pin_s1 <= 1'b1;
            q.pin_s2 <= 1'b1;
        end
        else
            q <= next_q;
    end

    assign wb_dat_o = q.wb_dat;
    assign wb_ack_o = q.wb_ack;
    assign int_pin_o = q.int_out;
    assign int_pin_oe_n_o = q.int_oe_n;
    assign irq_o = q.irq;

endmodule // light_measurement_ctrl

// [shared/light_measurement_regs.svh]
// register offsets, field positions, reset values and timing counts of the light measurement block
// assumes byte addresses on a 32-bit register bus, one register per aligned word
`ifndef LIGHT_MEASUREMENT_REGS_SVH
`define LIGHT_MEASUREMENT_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define LM_ENABLE_OFS 8'h00
`define LM_ITIME_OFS 8'h04
`define LM_WTIME_OFS 8'h08
`define LM_CONFIG_OFS 8'h0C
`define LM_THR_LO_OFS 8'h10
`define LM_THR_HI_OFS 8'h14
`define LM_PERSIST_OFS 8'h18
`define LM_GAIN_OFS 8'h1C
`define LM_STATUS_OFS 8'h20
`define LM_DATA_BB_OFS 8'h24
`define LM_DATA_IR_OFS 8'h28
`define LM_IRQ_STAT_OFS 8'h2C
`define LM_IRQ_CLEAR_OFS 8'h30
`define LM_IRQ_EN_OFS 8'h34

// ----------------------------------------
// fields
// ----------------------------------------
`define LM_EN_POWER 0
`define LM_EN_MEASURE 1
`define LM_EN_WAIT 3
`define LM_EN_IRQ 4
`define LM_EN_SLEEP_IRQ 6
`define LM_IRQ_THR 0
`define LM_IRQ_DONE 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define LM_ENABLE_RST 8'h00
`define LM_ITIME_RST 8'hFF
`define LM_WTIME_RST 8'hFF
`define LM_THR_LO_RST 16'h0000
`define LM_THR_HI_RST 16'hFFFF
`define LM_PERSIST_RST 4'h0
`define LM_GAIN_RST 2'h0

// ----------------------------------------
// timing and gain
// ----------------------------------------
`define LM_CLK_MHZ 20
`define LM_STEP_TIME_US 2730
`define LM_STEP_CYCLES (`LM_STEP_TIME_US * `LM_CLK_MHZ)
`define LM_STEP_FULL 12'h100
`define LM_LONG_WAIT_MUL 4'hC
`define LM_GAIN_X1 17'h0_0001
`define LM_GAIN_X8 17'h0_0008
`define LM_GAIN_X16 17'h0_0010
`define LM_GAIN_X120 17'h0_0078

`endif

// [shared/light_measurement_pkg.sv]
// types shared by the light measurement controller and its serial target
// assumes the constants header is included by each design file
package light_measurement_pkg;

    typedef enum logic [1:0] {seq_sleep, seq_integrate, seq_wait} seq_state_type;

    typedef enum logic [2:0] {i2c_idle, i2c_addr, i2c_write, i2c_ack_in, i2c_read, i2c_ack_out} i2c_state_type;

    typedef struct packed {
        logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
        i2c_state_type state;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic rw, first, nack, sda_oe_n, sda_out, wr_stb;
        logic [7:0] ptr, wr_addr, wr_data;
    } i2c_regs_type;

    typedef struct packed {
        logic bb_s1, bb_s2, bb_q, ir_s1, ir_s2, ir_q, pin_s1, pin_s2;
        logic [7:0] enable, itime, wtime;
        logic long_wait;
        logic [15:0] thr_lo, thr_hi;
        logic [3:0] persist;
        logic [1:0] gain, irq_stat, irq_en;
        seq_state_type state;
        logic [15:0] presc;
        logic [11:0] steps;
        logic [15:0] acc_bb, acc_ir, data_bb, data_ir;
        logic valid, out_flag;
        logic [3:0] out_cnt;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic irq, int_oe_n, int_out;
    } ctrl_regs_type;

endpackage

// [rtl/i2c_register_target.sv]
// two-wire serial target giving byte access to the register map
// assumes scl and sda come from pins outside the clock domain; read data is valid for ptr_o
`timescale 1ns/10ps
`include "light_measurement_regs.svh"

module i2c_register_target #(
    parameter logic [6:0] TARGET_ADDR = 7'h2A
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [7:0] rd_data_i,
    output logic [7:0] ptr_o,
    output logic wr_stb_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o
);

    light_measurement_pkg::i2c_regs_type q;
    light_measurement_pkg::i2c_regs_type next_q;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    // ----------------------------------------
    // line events
    // ----------------------------------------
    // only the second sync stage and its delayed copy are looked at
    assign scl_rise = q.scl_s2 & ~q.scl_q;
    assign scl_fall = ~q.scl_s2 & q.scl_q;
    assign start_cond = q.scl_s2 & q.scl_q & q.sda_q & ~q.sda_s2;
    assign stop_cond = q.scl_s2 & q.scl_q & ~q.sda_q & q.sda_s2;

    // ----------------------------------------
    // protocol engine
    // ----------------------------------------
    always_comb
    begin
        next_q = q;
        next_q.wr_stb = 1'b0;
        next_q.scl_s1 = scl_i;
        next_q.scl_s2 = q.scl_s1;
        next_q.scl_q = q.scl_s2;
        next_q.sda_s1 = sda_i;
        next_q.sda_s2 = q.sda_s1;
        next_q.sda_q = q.sda_s2;
        if (start_cond)
        begin
            next_q.state = light_measurement_pkg::i2c_addr;
            next_q.bitcnt = 4'h0;
            next_q.sda_oe_n = 1'b1;
            next_q.first = 1'b1;
        end
        else if (stop_cond)
        begin
            next_q.state = light_measurement_pkg::i2c_idle;
            next_q.sda_oe_n = 1'b1;
        end
        else
        begin
            unique case (q.state)
                light_measurement_pkg::i2c_idle: ;
                light_measurement_pkg::i2c_addr, light_measurement_pkg::i2c_write:
                begin
                    if (scl_rise)
                    begin
                        next_q.shift = {q.shift[6:0], q.sda_s2};
                        next_q.bitcnt = q.bitcnt + 4'h1;
                    end
                    else if (scl_fall && q.bitcnt == 4'h8)
                    begin
                        next_q.state = light_measurement_pkg::i2c_ack_in;
                        next_q.sda_oe_n = 1'b0;
                        if (q.state == light_measurement_pkg::i2c_addr)
                        begin
                            next_q.rw = q.shift[0];
                            // foreign address: stay off the bus until the next start
                            if (q.shift[7:1] != TARGET_ADDR)
                            begin
                                next_q.state = light_measurement_pkg::i2c_idle;
                                next_q.sda_oe_n = 1'b1;
                            end
                        end
                        else if (q.first)
                        begin
                            next_q.ptr = q.shift;
                            next_q.first = 1'b0;
                        end
                        else
                        begin
                            next_q.wr_stb = 1'b1;
                            next_q.wr_addr = q.ptr;
                            next_q.wr_data = q.shift;
                            next_q.ptr = q.ptr + 8'h01;
                        end
                    end
                end
                light_measurement_pkg::i2c_ack_in, light_measurement_pkg::i2c_ack_out:
                begin
                    if (scl_rise && q.state == light_measurement_pkg::i2c_ack_out)
                        next_q.nack = q.sda_s2;
                    if (scl_fall)
                    begin
                        next_q.bitcnt = 4'h0;
                        next_q.sda_oe_n = 1'b1;
                        if (q.state == light_measurement_pkg::i2c_ack_out && q.nack)
                            next_q.state = light_measurement_pkg::i2c_idle;
                        else if (q.rw)
                        begin
                            next_q.state = light_measurement_pkg::i2c_read;
                            next_q.shift = rd_data_i;
                            next_q.sda_oe_n = rd_data_i[7];
                            next_q.ptr = q.ptr + 8'h01;
                        end
                        else
                            next_q.state = light_measurement_pkg::i2c_write;
                    end
                end
                light_measurement_pkg::i2c_read:
                begin
                    if (scl_fall)
                    begin
                        if (q.bitcnt == 4'h7)
                        begin
                            next_q.state = light_measurement_pkg::i2c_ack_out;
                            next_q.sda_oe_n = 1'b1;
                        end
                        else
                        begin
                            next_q.shift = {q.shift[6:0], 1'b0};
                            next_q.sda_oe_n = q.shift[6];
                            next_q.bitcnt = q.bitcnt + 4'h1;
                        end
                    end
                end
                default: next_q.state = light_measurement_pkg::i2c_idle;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.scl_q <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_q <= 1'b1;
            q.state <= light_measurement_pkg::i2c_idle;
            q.sda_oe_n <= 1'b1;
        end
        else
            q <= next_q;
    end

    assign sda_o = q.sda_out;
    assign sda_oe_n_o = q.sda_oe_n;
    assign ptr_o = q.ptr;
    assign wr_stb_o = q.wr_stb;
    assign wr_addr_o = q.wr_addr;
    assign wr_data_o = q.wr_data;

endmodule // i2c_register_target

// [test/light_measurement_assertions.sv]
// port checker for the light measurement controller
// assumes one clock domain; bound at the foot of this file
`timescale 1ns/10ps
module light_measurement_assertions #(
    parameter int STEP_CYCLES = 4
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sda_o,
    input wire logic int_pin_o,
    input wire logic int_pin_oe_n_o,
    input wire logic irq_o
);
    logic take;
    logic pin_en;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // shadow of the pin enable; serial writes to it are not followed
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_en <= 1'b0;
        else if (take && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0])
            pin_en <= wb_dat_i[4];
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_pin_held;
        !int_pin_oe_n_o && !(take && wb_we_i);
    endsequence
    sequence s_irq_held;
        irq_o && !(take && wb_we_i);
    endsequence
    AST_ACK_NEXT: assert property (take |=> wb_ack_o)
        else $error("ack missing");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(take))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    AST_OPEN_DRAIN: assert property (!sda_o && !int_pin_o)
        else $error("pin driven high");
    AST_PIN_HOLD: assert property (s_pin_held [*3] |=> !int_pin_oe_n_o)
        else $error("pin released early");
    AST_IRQ_HOLD: assert property (s_irq_held [*3] |=> irq_o)
        else $error("irq dropped early");
    AST_PIN_MASK: assert property (!pin_en [*3] |-> int_pin_oe_n_o)
        else $error("pin pulled while masked");
endmodule // light_measurement_assertions

bind light_measurement_ctrl light_measurement_assertions #(.STEP_CYCLES(STEP_CYCLES)) chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sda_o(sda_o), .int_pin_o(int_pin_o), .int_pin_oe_n_o(int_pin_oe_n_o),
    .irq_o(irq_o)
);

// [test/i2c_host_model.sv]
// serial bus controller model, 400 ns bit period
// assumes a pull-up on the data wire, formed in the bench
`timescale 1ns/10ps
module i2c_host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_rel_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_rel_o = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic start();
        hold(1);
        sda_rel_o <= 1'b1;
        hold(4);
        scl_o <= 1'b1;
        hold(4);
        sda_rel_o <= 1'b0;
        hold(4);
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        hold(1);
        sda_rel_o <= 1'b0;
        hold(4);
        scl_o <= 1'b1;
        hold(4);
        sda_rel_o <= 1'b1;
        hold(4);
    endtask
    // data moves one cycle after the clock falls, never with it
    task automatic bit_io(input logic b, output logic s);
        hold(1);
        sda_rel_o <= b;
        hold(4);
        scl_o <= 1'b1;
        hold(3);
        s = sda_i;
        scl_o <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ao, output logic [7:0] q, output logic ai);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ao, ai);
    endtask
endmodule // i2c_host_model

// [test/tb_light_measurement_ctrl.sv]
// self-checking bench for the light measurement controller
// assumes the port checker is bound from its own file
`timescale 1ns/10ps
module tb_light_measurement_ctrl;
    typedef struct packed {logic w; logic [7:0] ad; logic [31:0] d, e;} row_type;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, bb = 1'b0, ir = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] q8;
    logic [31:0] wdat = 32'h0, rd_o, rdat;
    logic ack, sda_oe_n, int_oe_n, irq, scl, sda_rel, a;
    wire logic sda = sda_rel & sda_oe_n;
    int error_cnt = 0, check_count = 0, cycles = 0;
    row_type rows [12] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0},
        '{1'b0, 8'h04, 32'h0, 32'hFF},
        '{1'b0, 8'h08, 32'h0, 32'hFF},
        '{1'b0, 8'h14, 32'h0, 32'hFFFF},
        '{1'b1, 8'h1C, 32'hFFFF_FFFF, 32'h3},
        '{1'b1, 8'h3C, 32'hFFFF_FFFF, 32'h0},
        '{1'b1, 8'h2C, 32'h3, 32'h0},
        '{1'b1, 8'h1C, 32'h1, 32'h1},
        '{1'b1, 8'h04, 32'h0, 32'h0},
        '{1'b1, 8'h14, 32'h40, 32'h40},
        '{1'b1, 8'h10, 32'h10, 32'h10},
        '{1'b1, 8'h18, 32'h2, 32'h2}
    };
    always #25 clk_i = ~clk_i;
    light_measurement_ctrl #(.STEP_CYCLES(4)) light_measurement_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack),
        .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n), .broadband_pulse_i(bb),
        .infrared_pulse_i(ir), .int_pin_i(int_oe_n), .int_pin_o(), .int_pin_oe_n_o(int_oe_n), .irq_o(irq)
    );
    i2c_host_model i2c_host_model_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_rel_o(sda_rel));
    task automatic close_out();
        if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // a hang ends the run as a failure
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            error_cnt++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, ad, d};
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        rdat = rd_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic sxfer(input logic [7:0] d);
        i2c_host_model_i.xfer(d, 1'b1, q8, a);
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_bit("pin idle", 1'b1, int_oe_n);
        foreach (rows[i])
        begin
            if (rows[i].w)
                wb(1'b1, rows[i].ad, rows[i].d);
            wb(1'b0, rows[i].ad, 32'h0);
            chk("register", rows[i].e, rdat);
        end
        i2c_host_model_i.start();
        sxfer({7'h2A, 1'b0});
        chk_bit("addr ack", 1'b0, a);
        sxfer(8'h08);
        sxfer(8'h5A);
        chk_bit("data ack", 1'b0, a);
        i2c_host_model_i.stop();
        wb(1'b0, 8'h08, 32'h0);
        chk("serial write", 32'h5A, rdat);
        i2c_host_model_i.start();
        sxfer({7'h2A, 1'b0});
        sxfer(8'h08);
        i2c_host_model_i.start();
        sxfer({7'h2A, 1'b1});
        sxfer(8'hFF);
        chk("serial read", 32'h5A, {24'h0, q8});
        i2c_host_model_i.stop();
        i2c_host_model_i.start();
        sxfer({7'h2B, 1'b0});
        chk_bit("foreign addr", 1'b1, a);
        i2c_host_model_i.stop();
        wb(1'b1, 8'h34, 32'h2);
        wb(1'b1, 8'h00, 32'h53);
        repeat (100) @(posedge clk_i);
        for (int i = 0; i < 10; i++)
        begin
            {bb, ir} <= {1'b1, i < 3};
            repeat (3) @(posedge clk_i);
            {bb, ir} <= 2'b00;
            repeat (3) @(posedge clk_i);
        end
        wb(1'b0, 8'h24, 32'h0);
        chk("early data", 32'h0, rdat);
        while (irq !== 1'b1)
            @(posedge clk_i);
        wb(1'b0, 8'h24, 32'h0);
        chk("broadband", 32'h50, rdat);
        wb(1'b0, 8'h28, 32'h0);
        chk("infrared", 32'h18, rdat);
        chk_bit("pin one event", 1'b1, int_oe_n);
        wb(1'b1, 8'h30, 32'h2);
        repeat (2) @(posedge clk_i);
        while (irq !== 1'b1)
            @(posedge clk_i);
        repeat (2) @(posedge clk_i);
        chk_bit("pin two events", 1'b0, int_oe_n);
        wb(1'b0, 8'h2C, 32'h0);
        chk("event status", 32'h3, rdat);
        repeat (50) @(posedge clk_i);
        wb(1'b0, 8'h20, 32'h0);
        chk("sleep state", 32'h0, rdat & 32'h18);
        chk_bit("pin held", 1'b0, int_oe_n);
        wb(1'b1, 8'h30, 32'h1);
        repeat (3) @(posedge clk_i);
        chk_bit("pin cleared", 1'b1, int_oe_n);
        wb(1'b1, 8'h00, 32'h0B);
        repeat (1100) @(posedge clk_i);
        wb(1'b0, 8'h20, 32'h0);
        chk("wait state", 32'h10, rdat & 32'h18);
        close_out();
    end
endmodule // tb_light_measurement_ctrl
